// [logic/acccr_correct.sv]
// Offset then gain correction of one 24-bit conversion result
`timescale 1ns/1ps
module acccr_correct import acccr_pkg::*; #(
  parameter int unsigned DW = 24
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          start_i,
  input  wire logic [DW-1:0] sample_i,
  input  wire logic [DW-1:0] offset_i,
  input  wire logic [DW-1:0] gain_i,
  output logic      [DW-1:0] result_o,
  output logic               done_o
);

  // Saturation limits and gain scaling assume a 24-bit word
  if (DW != 24) begin : g_dw_check
    $error("acccr_correct: width must be 24");
  end

  logic [DW-1:0] result_q, result_d;
  logic          done_q, done_d;
  logic signed [DW:0]      sum;
  logic signed [2*DW+1:0]  prod;
  logic signed [2*DW+1:0]  scaled;

  always_comb begin
    // Offset first, then gain scaling  (see RULE13)
    sum    = $signed({sample_i[DW-1], sample_i}) + $signed({offset_i[DW-1], offset_i});
    // Gain treated as unsigned 0.0 .. just under 2.0  (see RULE2)
    prod   = sum * $signed({1'b0, gain_i});
    scaled = prod >>> ACCCR_GAIN_FRAC;
    result_d = result_q;
    done_d   = 1'b0;
    if (start_i) begin
      if (scaled > $signed({{(DW+3){1'b0}}, {(DW-1){1'b1}}})) begin
        result_d = {1'b0, {(DW-1){1'b1}}};
      end else if (scaled < -$signed({{(DW+2){1'b0}}, 1'b1, {(DW-1){1'b0}}})) begin
        result_d = {1'b1, {(DW-1){1'b0}}};
      end else begin
        result_d = scaled[DW-1:0];
      end
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q <= '0;
      done_q   <= 1'b0;
    end else if (ce_i) begin
      result_q <= result_d;
      done_q   <= done_d;
    end
  end

  assign result_o = result_q;
  assign done_o   = done_q;

endmodule // acccr_correct

// [logic/acccr_pkg.sv]
// Register map, field layout and reset constants of the calibration bank
package acccr_pkg;

  localparam int unsigned ACCCR_DW = 32;
  localparam int unsigned ACCCR_AW = 8;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [5:0] ACCCR_IDX_CH0_GAIN_HIGH = 6'h0c;
  localparam logic [5:0] ACCCR_IDX_CH0_GAIN_LOW  = 6'h0d;
  localparam logic [5:0] ACCCR_IDX_CH1_PHASE_INPUT_CONFIG       = 6'h0e;
  localparam logic [5:0] ACCCR_IDX_CH1_OFS_HIGH  = 6'h0f;
  localparam logic [5:0] ACCCR_IDX_CH1_OFS_LOW   = 6'h10;
  // Datapath sample input and corrected result registers
  localparam logic [5:0] ACCCR_IDX_SAMPLE_IN     = 6'h20;
  localparam logic [5:0] ACCCR_IDX_RESULT        = 6'h21;

  localparam logic [15:0] ACCCR_RST_CH0_GAIN_HIGH = 16'h8000;
  localparam logic [15:0] ACCCR_RST_CH0_GAIN_LOW  = 16'h0000;
  localparam logic [15:0] ACCCR_RST_CH1_PHASE_INPUT_CONFIG       = 16'h0000;
  localparam logic [15:0] ACCCR_RST_CH1_OFS_HIGH  = 16'h0000;
  localparam logic [15:0] ACCCR_RST_CH1_OFS_LOW   = 16'h0000;

  // Field positions
  localparam int unsigned ACCCR_LOW_BYTE_LSB  = 8;
  localparam int unsigned ACCCR_PHASE_LSB     = 6;
  localparam int unsigned ACCCR_PHASE_W       = 10;
  localparam int unsigned ACCCR_SEL_LSB       = 0;
  localparam int unsigned ACCCR_SEL_W         = 2;

  // Gain word has 23 fractional bits: 800000h is unity
  localparam int unsigned ACCCR_GAIN_FRAC     = 23;

  typedef enum logic [1:0] {
    ACCCR_SEL_PINS    = 2'h0,
    ACCCR_SEL_SHORTED = 2'h1,
    ACCCR_SEL_DC_DIAG = 2'h2,
    ACCCR_SEL_AC_DIAG = 2'h3
  } acccr_sel_type;

endpackage

// [logic/acccr_regs.sv]
// Calibration and channel configuration register bank with Wishbone slave
// Operation
// RULE1 - Channel 0 gain low byte lives in bits 15:8 of gain low register.
// RULE2 - Gain word is unsigned, spanning 0.0 to just below 2.0.
// RULE3 - Channel 1 phase delay is a signed 10-bit field in bits 15:6.
// RULE4 - Input select bits 1:0: 00 analog pins, 01 inputs shorted.
// RULE5 - Input select 10 routes DC diagnostic, 11 routes AC diagnostic.
// RULE6 - Configuration bits 5:2 are read-only and read zero.
// RULE7 - Offset high register holds offset bits 23:8; word is two's complement.
// RULE8 - Offset low byte in bits 15:8; bits 7:0 read zero, read-only.
// RULE9 - Channel 1 configuration at index 0Eh, resets to zero.
// RULE10 - Offset high at 0Fh, offset low at 10h, both reset to zero.
// RULE11 - Channel 0 gain low register at 0Dh, resets to zero.
// RULE12 - Channel 0 gain high word at 0Ch, resets to 8000h.
// RULE13 - Words join high word over low byte; offset applied before gain.
`timescale 1ns/1ps
module acccr_regs import acccr_pkg::*; (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [ACCCR_AW-1:0] wb_adr_i,
  input  wire logic [ACCCR_DW-1:0] wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  output logic      [ACCCR_DW-1:0] wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     wb_err_o,
  output logic      [23:0]         ch0_gain_o,
  output logic      [9:0]          ch1_phase_delay_o,
  output logic                     ch1_pins_connect_o,
  output logic                     ch1_inputs_short_o,
  output logic                     ch1_dc_diag_o,
  output logic                     ch1_ac_diag_o,
  output logic      [23:0]         ch1_offset_o,
  output logic      [23:0]         ch1_result_o,
  output logic                     ch1_result_valid_o
);

  logic [15:0]   ch0_gain_high_word_q, ch0_gain_high_word_d;
  logic [7:0]    ch0_gain_low_byte_q,  ch0_gain_low_byte_d;
  logic [9:0]    ch1_phase_delay_q,    ch1_phase_delay_d;
  acccr_sel_type ch1_input_select_q,   ch1_input_select_d;
  logic [15:0]   ch1_offset_high_word_q, ch1_offset_high_word_d;
  logic [7:0]    ch1_offset_low_byte_q,  ch1_offset_low_byte_d;
  logic [23:0]   sample_q, sample_d;
  logic          start_q, start_d;
  logic          ack_q, ack_d;
  logic          err_q, err_d;
  logic [ACCCR_DW-1:0] rdata_q, rdata_d;
  logic [3:0]    sel_dec_q, sel_dec_d;
  logic [23:0]   gain_word;
  logic [23:0]   offset_word;
  logic [23:0]   corr_result;
  logic          corr_done;
  logic [5:0]    idx;
  logic          req;
  logic          wr_lo;
  logic          wr_hi;

  assign idx   = wb_adr_i[7:2];
  assign req   = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign wr_lo = req && wb_we_i && wb_sel_i[0];
  assign wr_hi = req && wb_we_i && wb_sel_i[1];

  // Full 24-bit calibration words  (see RULE13)
  assign gain_word   = {ch0_gain_high_word_q, ch0_gain_low_byte_q};
  assign offset_word = {ch1_offset_high_word_q, ch1_offset_low_byte_q};

  function automatic logic idx_mapped(input logic [5:0] i);
    idx_mapped = (i == ACCCR_IDX_CH0_GAIN_HIGH) || (i == ACCCR_IDX_CH0_GAIN_LOW) ||
                 (i == ACCCR_IDX_CH1_PHASE_INPUT_CONFIG) || (i == ACCCR_IDX_CH1_OFS_HIGH) ||
                 (i == ACCCR_IDX_CH1_OFS_LOW) || (i == ACCCR_IDX_SAMPLE_IN) ||
                 (i == ACCCR_IDX_RESULT);
  endfunction

  // Register writes
  always_comb begin
    ch0_gain_high_word_d   = ch0_gain_high_word_q;
    ch0_gain_low_byte_d    = ch0_gain_low_byte_q;
    ch1_phase_delay_d      = ch1_phase_delay_q;
    ch1_input_select_d     = ch1_input_select_q;
    ch1_offset_high_word_d = ch1_offset_high_word_q;
    ch1_offset_low_byte_d  = ch1_offset_low_byte_q;
    sample_d               = sample_q;
    start_d                = 1'b0;
    unique case (idx)
      ACCCR_IDX_CH0_GAIN_HIGH: begin
        if (wr_lo) ch0_gain_high_word_d[7:0] = wb_dat_i[7:0]; // see RULE12
        if (wr_hi) ch0_gain_high_word_d[15:8] = wb_dat_i[15:8]; // see RULE12
      end
      ACCCR_IDX_CH0_GAIN_LOW: begin
        if (wr_hi) ch0_gain_low_byte_d = wb_dat_i[15:8]; // see RULE1
      end
      ACCCR_IDX_CH1_PHASE_INPUT_CONFIG: begin
        if (wr_hi) ch1_phase_delay_d[9:2] = wb_dat_i[15:8]; // see RULE3
        if (wr_lo) begin
          ch1_phase_delay_d[1:0] = wb_dat_i[7:6]; // see RULE3
          ch1_input_select_d = acccr_sel_type'(wb_dat_i[1:0]); // see RULE4
        end
      end
      ACCCR_IDX_CH1_OFS_HIGH: begin
        if (wr_lo) ch1_offset_high_word_d[7:0] = wb_dat_i[7:0]; // see RULE7
        if (wr_hi) ch1_offset_high_word_d[15:8] = wb_dat_i[15:8]; // see RULE7
      end
      ACCCR_IDX_CH1_OFS_LOW: begin
        if (wr_hi) ch1_offset_low_byte_d = wb_dat_i[15:8]; // see RULE8
      end
      ACCCR_IDX_SAMPLE_IN: begin
        if (req && wb_we_i) begin
          if (wb_sel_i[0]) sample_d[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) sample_d[15:8] = wb_dat_i[15:8];
          if (wb_sel_i[2]) sample_d[23:16] = wb_dat_i[23:16];
          start_d = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  // Bus answer: ack or err one cycle after the request is seen
  always_comb begin
    ack_d     = 1'b0;
    err_d     = 1'b0;
    rdata_d   = rdata_q;
    sel_dec_d = {ch1_input_select_q == ACCCR_SEL_AC_DIAG,
                 ch1_input_select_q == ACCCR_SEL_DC_DIAG,
                 ch1_input_select_q == ACCCR_SEL_SHORTED,
                 ch1_input_select_q == ACCCR_SEL_PINS};
    if (req) begin
      ack_d   = idx_mapped(idx);
      err_d   = !idx_mapped(idx);
      rdata_d = '0;
      unique case (idx)
        ACCCR_IDX_CH0_GAIN_HIGH: rdata_d[15:0] = ch0_gain_high_word_q;
        ACCCR_IDX_CH0_GAIN_LOW:  rdata_d[15:8] = ch0_gain_low_byte_q; // see RULE1
        ACCCR_IDX_CH1_PHASE_INPUT_CONFIG: begin
          rdata_d[15:6] = ch1_phase_delay_q;
          rdata_d[5:2]  = 4'h0; // see RULE6
          rdata_d[1:0]  = ch1_input_select_q;
        end
        ACCCR_IDX_CH1_OFS_HIGH:  rdata_d[15:0] = ch1_offset_high_word_q;
        ACCCR_IDX_CH1_OFS_LOW:   rdata_d[15:8] = ch1_offset_low_byte_q; // see RULE8
        ACCCR_IDX_SAMPLE_IN:     rdata_d[23:0] = sample_q;
        ACCCR_IDX_RESULT:        rdata_d[23:0] = corr_result;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch0_gain_high_word_q   <= ACCCR_RST_CH0_GAIN_HIGH; // see RULE12
      ch0_gain_low_byte_q    <= ACCCR_RST_CH0_GAIN_LOW[15:8]; // see RULE11
      ch1_phase_delay_q      <= ACCCR_RST_CH1_PHASE_INPUT_CONFIG[15:6]; // see RULE9
      ch1_input_select_q     <= ACCCR_SEL_PINS; // see RULE9
      ch1_offset_high_word_q <= ACCCR_RST_CH1_OFS_HIGH; // see RULE10
      ch1_offset_low_byte_q  <= ACCCR_RST_CH1_OFS_LOW[15:8]; // see RULE10
      sample_q               <= '0;
      start_q                <= 1'b0;
      ack_q                  <= 1'b0;
      err_q                  <= 1'b0;
      rdata_q                <= '0;
      sel_dec_q              <= 4'h1;
    end else if (ce_i) begin
      ch0_gain_high_word_q   <= ch0_gain_high_word_d;
      ch0_gain_low_byte_q    <= ch0_gain_low_byte_d;
      ch1_phase_delay_q      <= ch1_phase_delay_d;
      ch1_input_select_q     <= ch1_input_select_d;
      ch1_offset_high_word_q <= ch1_offset_high_word_d;
      ch1_offset_low_byte_q  <= ch1_offset_low_byte_d;
      sample_q               <= sample_d;
      start_q                <= start_d;
      ack_q                  <= ack_d;
      err_q                  <= err_d;
      rdata_q                <= rdata_d;
      sel_dec_q              <= sel_dec_d; // see RULE5
    end
  end

  acccr_correct #(
    .DW (24)
  ) u_correct (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .start_i  (start_q),
    .sample_i (sample_q),
    .offset_i (offset_word),
    .gain_i   (gain_word),
    .result_o (corr_result),
    .done_o   (corr_done)
  );

  assign wb_dat_o           = rdata_q;
  assign wb_ack_o           = ack_q;
  assign wb_err_o           = err_q;
  assign ch0_gain_o         = gain_word;
  assign ch1_phase_delay_o  = ch1_phase_delay_q;
  assign ch1_offset_o       = offset_word;
  assign ch1_pins_connect_o = sel_dec_q[0]; // see RULE4
  assign ch1_inputs_short_o = sel_dec_q[1]; // see RULE4
  assign ch1_dc_diag_o      = sel_dec_q[2]; // see RULE5
  assign ch1_ac_diag_o      = sel_dec_q[3]; // see RULE5
  assign ch1_result_o       = corr_result;
  assign ch1_result_valid_o = corr_done;

  // Checks
  gain_reset_a: assert property (@(posedge clk_i) $past(rst_i) |-> ch0_gain_o == 24'h800000) // see RULE12
    else $error("gain word not unity after reset");
  cfg_reset_a: assert property (@(posedge clk_i) $past(rst_i) |-> ch1_phase_delay_o == 10'h000 && ch1_pins_connect_o) // see RULE9
    else $error("channel 1 config not zero after reset");
  ofs_reset_a: assert property (@(posedge clk_i) $past(rst_i) |-> ch1_offset_o == 24'h000000) // see RULE10
    else $error("offset not zero after reset");
  cfg_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(idx == ACCCR_IDX_CH1_PHASE_INPUT_CONFIG) |-> wb_dat_o[5:2] == 4'h0) // see RULE6
    else $error("reserved config bits read nonzero");
  low_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && ($past(idx) == ACCCR_IDX_CH1_OFS_LOW || $past(idx) == ACCCR_IDX_CH0_GAIN_LOW)
      |-> wb_dat_o[7:0] == 8'h00) // see RULE8
    else $error("low register reserved byte nonzero");
  gain_low_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_hi && idx == ACCCR_IDX_CH0_GAIN_LOW |=> ch0_gain_o[7:0] == $past(wb_dat_i[15:8])) // see RULE1
    else $error("gain low byte not stored from bits 15:8");
  ofs_high_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_hi && wr_lo && idx == ACCCR_IDX_CH1_OFS_HIGH
      |=> ch1_offset_o[23:8] == $past(wb_dat_i[15:0])) // see RULE7
    else $error("offset high word not stored");
  phase_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_hi && wr_lo && idx == ACCCR_IDX_CH1_PHASE_INPUT_CONFIG
      |=> ch1_phase_delay_o == $past(wb_dat_i[15:6])) // see RULE3
    else $error("phase delay not stored from bits 15:6");
  sel_onehot_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot({ch1_ac_diag_o, ch1_dc_diag_o, ch1_inputs_short_o, ch1_pins_connect_o})) // see RULE5
    else $error("input selection outputs not one-hot");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) // ack lasts one cycle
    else $error("ack held longer than one cycle");

endmodule // acccr_regs

// [test/acccr_tb.sv]
// Self-checking testbench for the calibration and configuration register bank
`timescale 1ns/1ps
module testbench;
  import acccr_pkg::*;

  logic                clk_i;
  logic                rst_i;
  logic                ce_i;
  logic                wb_cyc_i;
  logic                wb_stb_i;
  logic                wb_we_i;
  logic [ACCCR_AW-1:0] wb_adr_i;
  logic [ACCCR_DW-1:0] wb_dat_i;
  logic [3:0]          wb_sel_i;
  logic [ACCCR_DW-1:0] wb_dat_o;
  logic                wb_ack_o;
  logic                wb_err_o;
  logic [23:0]         ch0_gain_o;
  logic [9:0]          ch1_phase_delay_o;
  logic                pins_o;
  logic                short_o;
  logic                dc_o;
  logic                ac_o;
  logic [23:0]         ch1_offset_o;
  logic [23:0]         ch1_result_o;
  logic                valid_o;
  int                  err_total = 0;
  int                  n_checks = 0;

  acccr_regs dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .ch0_gain_o(ch0_gain_o),
    .ch1_phase_delay_o(ch1_phase_delay_o), .ch1_pins_connect_o(pins_o),
    .ch1_inputs_short_o(short_o), .ch1_dc_diag_o(dc_o), .ch1_ac_diag_o(ac_o),
    .ch1_offset_o(ch1_offset_o), .ch1_result_o(ch1_result_o), .ch1_result_valid_o(valid_o)
  );

  always #2.5 clk_i = ~clk_i;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle: held until ack or err is sampled high, then released
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("wrong value bus_answer expected 1 seen 0");
      end_of_test;
    end
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic        e;
    bus(1'b1, a, d, s, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    bus(1'b0, a, 32'h0, 4'hf, q, e);
  endtask

  task automatic test_reset;
    logic [31:0] q;
    rd(8'h30, q); chk("gain_high", q, 32'h00008000);
    rd(8'h34, q); chk("gain_low", q, 32'h00000000);
    rd(8'h38, q); chk("config", q, 32'h00000000);
    rd(8'h3c, q); chk("offset_high", q, 32'h00000000);
    rd(8'h40, q); chk("offset_low", q, 32'h00000000);
    chk("gain_out", {8'h0, ch0_gain_o}, 32'h00800000);
    chk("pins_out", {31'h0, pins_o}, 32'h1);
    $display("test reset values done");
  endtask

  task automatic test_fields;
    logic [31:0] q;
    wr(8'h38, 32'h0000ffff, 4'h3);
    rd(8'h38, q); chk("config_ro", q, 32'h0000ffc3);
    chk("phase_out", {22'h0, ch1_phase_delay_o}, 32'h000003ff);
    wr(8'h34, 32'h0000ffff, 4'h3);
    rd(8'h34, q); chk("gain_low_ro", q, 32'h0000ff00);
    chk("gain_join", {8'h0, ch0_gain_o}, 32'h008000ff);
    wr(8'h3c, 32'h0000a5c3, 4'h3);
    wr(8'h40, 32'h0000ffff, 4'h3);
    rd(8'h40, q); chk("offset_low_ro", q, 32'h0000ff00);
    rd(8'h3c, q); chk("offset_high_rw", q, 32'h0000a5c3);
    chk("offset_join", {8'h0, ch1_offset_o}, 32'h00a5c3ff);
    wr(8'h30, 32'h00001234, 4'h1);
    rd(8'h30, q); chk("gain_lane", q, 32'h00008034);
    $display("test field layout done");
  endtask

  task automatic test_select;
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      wr(8'h38, {30'h0, i[1:0]}, 4'h3);
      rd(8'h38, q);
      chk("select_rb", q, {30'h0, i[1:0]});
      chk("decode", {28'h0, ac_o, dc_o, short_o, pins_o}, 32'h1 << i);
    end
    $display("test input select done");
  endtask

  task automatic test_unmapped;
    logic [31:0] q;
    logic        e;
    bus(1'b1, 8'h00, 32'h0000ffff, 4'hf, q, e);
    chk("err_write", {31'h0, e}, 32'h1);
    bus(1'b0, 8'h44, 32'h0, 4'hf, q, e);
    chk("err_read", {31'h0, e}, 32'h1);
    chk("err_data", q, 32'h0);
    $display("test unmapped access done");
  endtask

  task automatic corr(input logic [15:0] gh, input logic [7:0] gl, input logic [15:0] oh,
                      input logic [7:0] ol, input logic [23:0] s, input logic [23:0] exp);
    logic [31:0] q;
    wr(8'h30, {16'h0, gh}, 4'h3);
    wr(8'h34, {16'h0, gl, 8'h00}, 4'h2);
    wr(8'h3c, {16'h0, oh}, 4'h3);
    wr(8'h40, {16'h0, ol, 8'h00}, 4'h2);
    wr(8'h80, {8'h0, s}, 4'h7);
    @(posedge clk_i);
    chk("valid_rise", {31'h0, valid_o}, 32'h1);
    @(posedge clk_i);
    chk("valid_fall", {31'h0, valid_o}, 32'h0);
    rd(8'h84, q);
    chk("result", q, {8'h0, exp});
  endtask

  task automatic test_datapath;
    corr(16'h4000, 8'h00, 16'h0000, 8'h10, 24'h000100, 24'h000088);
    corr(16'h4000, 8'h00, 16'hffff, 8'hf0, 24'h000120, 24'h000088);
    corr(16'h4000, 8'h00, 16'h0000, 8'h10, 24'hffff00, 24'hffff88);
    corr(16'hffff, 8'hff, 16'h0000, 8'h00, 24'h000100, 24'h0001ff);
    chk("result_out", {8'h0, ch1_result_o}, 32'h000001ff);
    $display("test correction path done");
  endtask

  // Request held while the clock enable is low must wait, then complete
  task automatic test_freeze;
    logic [31:0] q;
    @(posedge clk_i);
    ce_i     <= 1'b0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= 1'b1;
    wb_adr_i <= 8'h3c;
    wb_dat_i <= 32'h00001111;
    wb_sel_i <= 4'h3;
    repeat (3) @(posedge clk_i);
    chk("freeze_ack", {31'h0, wb_ack_o}, 32'h0);
    chk("freeze_offset", {8'h0, ch1_offset_o}, 32'h0);
    ce_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    rd(8'h3c, q); chk("thaw_offset", q, 32'h00001111);
    $display("test clock enable freeze done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset;
    test_fields;
    test_select;
    test_unmapped;
    test_datapath;
    test_freeze;
    end_of_test;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(20000 * 5);
    err_total++;
    end_of_test;
  end
endmodule // testbench
